// ### verilog/dacc_params.svh
`ifndef DACC_PARAMS_SVH
`define DACC_PARAMS_SVH
// register addresses on the peripheral bus
`define DACC_ADDR_CLKEN 20'hf007a
`define DACC_ADDR_VAL0 20'hfff34
`define DACC_ADDR_VAL1 20'hfff35
`define DACC_ADDR_MODE 20'hfff36
// field positions
`define DACC_GATE_BIT 7
`define DACC_ON0_BIT 4
`define DACC_ON1_BIT 5
`define DACC_TRIG0_BIT 0
`define DACC_TRIG1_BIT 1
// reset values
`define DACC_REG_RST 8'h00
// timing
`define DACC_SETTLE_NS 1000
`define DACC_CLK_NS 10
`define DACC_SETTLE_CYC ((`DACC_SETTLE_NS) / (`DACC_CLK_NS))
`define DACC_TRIG_DELAY 3
`define DACC_TRIG_GUARD 3
`endif

// ### verilog/dacc_pkg.sv
package dacc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [19:0] addr;
        logic [7:0] wdata;
    } dacc_bus_t;
    typedef enum logic [1:0] {
        DACC_IDLE,
        DACC_WAIT,
        DACC_SETTLE
    } dacc_state_t;
endpackage

// ### verilog/dacc_channel.sv
`include "dacc_params.svh"
// one converter channel: latch timing, settling counter, trigger guard
module dacc_channel
    import dacc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control from registers
    input wire logic convOn,
    input wire logic trigMode,
    input wire logic [7:0] value,
    input wire logic valueWr,
    input wire logic onRise,
    // event trigger, same clock
    input wire logic trigger,
    // results
    output logic [7:0] latchOut,
    output logic outValid
);
    localparam int SETTLE = (`DACC_SETTLE_CYC < 1) ? 1 : `DACC_SETTLE_CYC;
    logic [15:0] settleCnt_r;
    logic [1:0] guardCnt_r;
    logic [1:0] delayCnt_r;
    logic trigPend_r;
    logic wrDly_r;
    logic accept;
    logic loadNow;
    logic rtActive;

    assign rtActive = trigMode && convOn;
    // accepted trigger: not inside guard window of an earlier one
    assign accept = rtActive && trigger && (guardCnt_r == 2'h0);
    // latch loads when delayed write completes outside trigger mode, or when delayed trigger completes
    assign loadNow = (!rtActive && wrDly_r) || (trigPend_r && delayCnt_r == 2'h1);

    // write reaches latch one cycle later
    always_ff @(posedge clk) begin
        if (reset) begin
            wrDly_r <= 1'b0;
        end else begin
            wrDly_r <= valueWr;
        end
    end

    // trigger guard window of three cycles
    always_ff @(posedge clk) begin
        if (reset) begin
            guardCnt_r <= 2'h0;
        end else if (accept) begin
            guardCnt_r <= 2'(`DACC_TRIG_GUARD);
        end else if (guardCnt_r != 2'h0) begin
            guardCnt_r <= guardCnt_r - 2'h1;
        end
    end

    // trigger-to-latch delay of three cycles
    always_ff @(posedge clk) begin
        if (reset) begin
            trigPend_r <= 1'b0;
            delayCnt_r <= 2'h0;
        end else if (accept) begin
            trigPend_r <= 1'b1;
            delayCnt_r <= 2'(`DACC_TRIG_DELAY);
        end else if (trigPend_r) begin
            delayCnt_r <= delayCnt_r - 2'h1;
            if (delayCnt_r == 2'h1) begin
                trigPend_r <= 1'b0;
            end
        end
    end

    // output data latch holds last result
    always_ff @(posedge clk) begin
        if (reset) begin
            latchOut <= `DACC_REG_RST;
        end else if (loadNow) begin
            latchOut <= value;
        end
    end

    // settling down-counter, restarted by every new conversion
    always_ff @(posedge clk) begin
        if (reset) begin
            settleCnt_r <= 16'h0000;
        end else if (!convOn) begin
            settleCnt_r <= 16'h0000;
        end else if (onRise || (loadNow && (wrDly_r || trigPend_r))) begin
            settleCnt_r <= 16'(SETTLE);
        end else if (settleCnt_r != 16'h0000) begin
            settleCnt_r <= settleCnt_r - 16'h0001;
        end
    end

    assign outValid = convOn && (settleCnt_r == 16'h0000) && !onRise;

    a_guard_window: assert property (@(posedge clk) disable iff (reset)
        accept |=> !accept [*3])
        else $error("trigger accepted inside guard window");
    a_trig_latch: assert property (@(posedge clk) disable iff (reset)
        accept |-> ##4 (latchOut == $past(value)))
        else $error("latch not loaded three cycles after trigger");
    a_write_latch: assert property (@(posedge clk) disable iff (reset)
        (valueWr && !rtActive) |=> ##1 (latchOut == $past(value)) || rtActive)
        else $error("write did not reach latch one cycle later");
    a_settle_restart: assert property (@(posedge clk) disable iff (reset)
        (convOn && onRise) |=> !outValid)
        else $error("output valid right after enable");
endmodule

// ### verilog/dacc_top.sv
`include "dacc_params.svh"
module dacc_top
    import dacc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // peripheral bus
    input wire dacc_bus_t bus,
    output logic [7:0] rdata,
    // event triggers, same clock
    input wire logic eventTriggerCh0,
    input wire logic eventTriggerCh1,
    // output data latches to the ladders, and their output valid flags
    output logic [7:0] analogOutputPin0,
    output logic [7:0] analogOutputPin1,
    output logic outValid0,
    output logic outValid1
);
    logic [7:0] peripheralClockEnable_r;
    logic [7:0] converterModeControl_r;
    logic [7:0] channelOutputValue0_r;
    logic [7:0] channelOutputValue1_r;
    logic [1:0] onPrev_r;
    logic gate;
    logic blockReset;
    logic wrMode;
    logic wrVal0;
    logic wrVal1;
    logic [1:0] convOn;
    logic [1:0] trigMode;

    assign gate = peripheralClockEnable_r[`DACC_GATE_BIT];
    assign blockReset = reset || !gate;
    assign wrMode = bus.wr && gate && bus.addr == `DACC_ADDR_MODE;
    assign wrVal0 = bus.wr && gate && bus.addr == `DACC_ADDR_VAL0;
    assign wrVal1 = bus.wr && gate && bus.addr == `DACC_ADDR_VAL1;
    assign convOn = {converterModeControl_r[`DACC_ON1_BIT],
                     converterModeControl_r[`DACC_ON0_BIT]};
    assign trigMode = {converterModeControl_r[`DACC_TRIG1_BIT],
                       converterModeControl_r[`DACC_TRIG0_BIT]};

    // peripheral clock enable register, system reset only
    always_ff @(posedge clk) begin
        if (reset) begin
            peripheralClockEnable_r <= `DACC_REG_RST;
        end else if (bus.wr && bus.addr == `DACC_ADDR_CLKEN) begin
            peripheralClockEnable_r <= bus.wdata;
        end
    end

    // mode register, only defined bits kept
    always_ff @(posedge clk) begin
        if (blockReset) begin
            converterModeControl_r <= `DACC_REG_RST;
        end else if (wrMode) begin
            converterModeControl_r <= bus.wdata & 8'h33;
        end
    end

    // channel value registers
    always_ff @(posedge clk) begin
        if (blockReset) begin
            channelOutputValue0_r <= `DACC_REG_RST;
            channelOutputValue1_r <= `DACC_REG_RST;
        end else begin
            if (wrVal0) begin
                channelOutputValue0_r <= bus.wdata;
            end
            if (wrVal1) begin
                channelOutputValue1_r <= bus.wdata;
            end
        end
    end

    // on-bit edge history for settling restart
    always_ff @(posedge clk) begin
        if (blockReset) begin
            onPrev_r <= 2'h0;
        end else begin
            onPrev_r <= convOn;
        end
    end

    // read data register; gated block reads defaults
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `DACC_ADDR_CLKEN: rdata <= peripheralClockEnable_r;
                `DACC_ADDR_MODE: rdata <= converterModeControl_r;
                `DACC_ADDR_VAL0: rdata <= channelOutputValue0_r;
                `DACC_ADDR_VAL1: rdata <= channelOutputValue1_r;
                default: rdata <= 8'h00;
            endcase
        end
    end

    // channel 0
    dacc_channel u_ch0 (
        .clk(clk),
        .reset(blockReset),
        .convOn(convOn[0]),
        .trigMode(trigMode[0]),
        .value(channelOutputValue0_r),
        .valueWr(wrVal0),
        .onRise(convOn[0] && !onPrev_r[0]),
        .trigger(eventTriggerCh0),
        .latchOut(analogOutputPin0),
        .outValid(outValid0)
    );

    // channel 1
    dacc_channel u_ch1 (
        .clk(clk),
        .reset(blockReset),
        .convOn(convOn[1]),
        .trigMode(trigMode[1]),
        .value(channelOutputValue1_r),
        .valueWr(wrVal1),
        .onRise(convOn[1] && !onPrev_r[1]),
        .trigger(eventTriggerCh1),
        .latchOut(analogOutputPin1),
        .outValid(outValid1)
    );

    a_gate_clears: assert property (@(posedge clk) disable iff (reset)
        !gate |=> converterModeControl_r == 8'h00 && channelOutputValue0_r == 8'h00)
        else $error("registers not cleared while gated");
    a_gated_write: assert property (@(posedge clk) disable iff (reset)
        (!gate && bus.wr && bus.addr == `DACC_ADDR_MODE) |=> converterModeControl_r == 8'h00)
        else $error("gated write took effect");
    a_mode_zeros: assert property (@(posedge clk) disable iff (reset)
        (converterModeControl_r & 8'hcc) == 8'h00)
        else $error("reserved mode bits set");
    a_ungated_write: assert property (@(posedge clk) disable iff (reset)
        wrVal1 |=> channelOutputValue1_r == $past(bus.wdata))
        else $error("value write lost");
endmodule

// ### testbench/dacc_event_src.sv
// event source model: copies each bench request to the trigger, one edge later and just as long
module dacc_event_src
    import dacc_pkg::*;
(
    // clock
    input wire logic clk,
    // requests from the bench, one bit a channel
    input wire logic [1:0] fire,
    // trigger pulses towards the converter
    output logic eventTriggerCh0,
    output logic eventTriggerCh1
);
    timeunit 1ns;
    timeprecision 1ps;
    // pulse launched just after the edge that saw the request
    initial begin
        eventTriggerCh0 = 1'b0;
        eventTriggerCh1 = 1'b0;
    end
    always @(posedge clk) begin
        eventTriggerCh0 <= #1 fire[0];
        eventTriggerCh1 <= #1 fire[1];
    end
endmodule

// ### testbench/test_dual_channel_dac_control.sv
`include "dacc_params.svh"
`define CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_dual_channel_dac_control import dacc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = `DACC_SETTLE_CYC;
    logic clk = 1'b0;
    logic reset = 1'b1;
    dacc_bus_t bus = '0;
    logic [1:0] fire = 2'b00;
    logic [7:0] rdata, pin0, pin1;
    logic trig0, trig1, valid0, valid1;
    int num_errors = 0;
    int checks_done = 0;
    int n0, n1;
    // clock, design and event source
    always #5 clk = ~clk;
    dacc_top dut_u (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
        .eventTriggerCh0(trig0), .eventTriggerCh1(trig1), .analogOutputPin0(pin0),
        .analogOutputPin1(pin1), .outValid0(valid0), .outValid1(valid1));
    dacc_event_src src_u (.clk(clk), .fire(fire), .eventTriggerCh0(trig0),
        .eventTriggerCh1(trig1));
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bus and trigger helpers, all launched just after an edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        step(1);
        bus = '{1'b1, 1'b0, a, d};
        step(1);
        bus.wr = 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] exp);
        step(1);
        bus = '{1'b0, 1'b1, a, 8'h00};
        step(1);
        bus.rd = 1'b0;
        step(1);
        `CHECK("rdata", exp, rdata)
    endtask
    task automatic pulse();
        step(1);
        fire[1] = 1'b1;
        step(1);
        fire[1] = 1'b0;
    endtask
    // cycles until the channel output is valid, bounded
    task automatic settle(input int ch, output int k);
        k = 0;
        while ((ch ? valid1 : valid0) !== 1'b1) begin
            step(1);
            k++;
            if (k > 4 * SC) begin
                num_errors++;
                $display("mismatch settle expected 1 seen 0");
                complete_run();
            end
        end
    endtask
    // gating and register defaults
    task automatic t_gate();
        wr(`DACC_ADDR_MODE, 8'h33);
        wr(`DACC_ADDR_VAL0, 8'h5a);
        rd(`DACC_ADDR_MODE, 8'h00);
        rd(`DACC_ADDR_VAL0, 8'h00);
        `CHECK("pin0 gated", 8'h00, pin0)
        wr(`DACC_ADDR_CLKEN, 8'h80);
        rd(`DACC_ADDR_CLKEN, 8'h80);
        rd(`DACC_ADDR_MODE, 8'h00);
        rd(`DACC_ADDR_VAL1, 8'h00);
        wr(`DACC_ADDR_MODE, 8'hff);
        rd(`DACC_ADDR_MODE, 8'h33);
        rd(20'hfff37, 8'h00);
        wr(`DACC_ADDR_MODE, 8'h00);
    endtask
    // normal mode: write timing, settling, abort, on-off-on
    task automatic t_normal();
        wr(`DACC_ADDR_VAL0, 8'h40);
        wr(`DACC_ADDR_MODE, 8'h10);
        settle(0, n0);
        `CHECK("settle on", 1'b1, n0 >= SC - 2 && n0 <= SC + 3)
        `CHECK("valid1 off", 1'b0, valid1)
        wr(`DACC_ADDR_VAL0, 8'hc3);
        `CHECK("pin0 early", 8'h40, pin0)
        step(1);
        `CHECK("pin0 late", 8'hc3, pin0)
        `CHECK("valid0 new", 1'b0, valid0)
        step(SC / 2);
        wr(`DACC_ADDR_VAL0, 8'h1e);
        step(1);
        `CHECK("pin0 rewrite", 8'h1e, pin0)
        settle(0, n0);
        `CHECK("settle restart", 1'b1, n0 >= SC - 3 && n0 <= SC + 3)
        wr(`DACC_ADDR_MODE, 8'h00);
        `CHECK("valid0 off", 1'b0, valid0)
        wr(`DACC_ADDR_MODE, 8'h10);
        step(SC / 2);
        wr(`DACC_ADDR_MODE, 8'h00);
        wr(`DACC_ADDR_MODE, 8'h10);
        settle(0, n0);
        `CHECK("settle last on", 1'b1, n0 >= SC - 2 && n0 <= SC + 3)
    endtask
    // event-triggered mode on channel 1
    task automatic t_trig();
        wr(`DACC_ADDR_VAL1, 8'h11);
        wr(`DACC_ADDR_MODE, 8'h30);
        settle(1, n0);
        wr(`DACC_ADDR_MODE, 8'h32);
        wr(`DACC_ADDR_VAL1, 8'h77);
        step(2);
        `CHECK("pin1 no trigger", 8'h11, pin1)
        pulse();
        step(3);
        `CHECK("pin1 early", 8'h11, pin1)
        step(1);
        `CHECK("pin1 late", 8'h77, pin1)
        `CHECK("pin0 other", 8'h1e, pin0)
        settle(1, n0);
        pulse();
        step(6);
        settle(1, n0);
        pulse();
        pulse();
        step(4);
        settle(1, n1);
        `CHECK("close trigger", n0, n1)
        pulse();
        step(2);
        pulse();
        step(6);
        settle(1, n1);
        `CHECK("abort trigger", n0, n1)
        step(3);
        wr(`DACC_ADDR_MODE, 8'h12);
        wr(`DACC_ADDR_VAL1, 8'h5c);
        `CHECK("pin1 off early", 8'h77, pin1)
        step(1);
        `CHECK("pin1 off late", 8'h5c, pin1)
    endtask
    // gate off clears everything
    task automatic t_clear();
        wr(`DACC_ADDR_VAL1, 8'h00);
        wr(`DACC_ADDR_CLKEN, 8'h00);
        step(1);
        `CHECK("pin0 cleared", 8'h00, pin0)
        `CHECK("valid0 cleared", 1'b0, valid0)
        wr(`DACC_ADDR_CLKEN, 8'h80);
        rd(`DACC_ADDR_MODE, 8'h00);
        rd(`DACC_ADDR_VAL0, 8'h00);
    endtask
    // main sequence
    initial begin
        step(20);
        reset = 1'b0;
        t_gate();
        t_normal();
        t_trig();
        t_clear();
        complete_run();
    end
endmodule
